// [shared/prs_pkg.sv]
// constants for the peripheral pin route select block
// assumes a byte-wide register port and six eight-pin i/o ports a..f
package prs_pkg;

  // register port widths
  localparam int ADDR_W = 8;   // byte address width
  localparam int DATA_W = 8;   // register data width

  // register offsets
  localparam logic [7:0] EVT_ROUTE_OFS = 8'h00;  // event output route
  localparam logic [7:0] TBL_ROUTE_OFS = 8'h01;  // logic-table output route
  localparam logic [7:0] SER_ROUTE_OFS = 8'h02;  // serial port route

  // reset values
  localparam logic [7:0] EVT_ROUTE_RST = 8'h00;
  localparam logic [7:0] TBL_ROUTE_RST = 8'h00;
  localparam logic [7:0] SER_ROUTE_RST = 8'h00;

  // implemented (read/write) bits of each register
  localparam logic [7:0] EVT_ROUTE_MASK = 8'h3F;  // bits 5:0
  localparam logic [7:0] TBL_ROUTE_MASK = 8'h0F;  // bits 3:0
  localparam logic [7:0] SER_ROUTE_MASK = 8'hFF;  // four 2-bit fields

  // number of routed signals of each kind
  localparam int EVT_NUM = 6;   // event outputs a..f
  localparam int TBL_NUM = 4;   // lookup-table outputs 0..3
  localparam int SER_NUM = 4;   // serial ports 0..3
  localparam int PORT_NUM = 6;  // i/o ports a..f
  localparam int SER_FIELD_W = 2;

  // event outputs that own an alternative pin: d, c and a
  localparam logic [5:0] EVT_ALT_MASK = 6'h0D;
  // every lookup table owns an alternative pin
  localparam logic [3:0] TBL_ALT_MASK = 4'hF;

  // pin positions inside a port
  localparam logic [2:0] EVT_DEF_PIN = 3'h2;  // default event pin
  localparam logic [2:0] EVT_ALT_PIN = 3'h7;  // alternative event pin
  localparam logic [2:0] TBL_DEF_PIN = 3'h3;  // default table pin
  localparam logic [2:0] TBL_ALT_PIN = 3'h6;  // alternative table pin

  // port indices
  localparam logic [2:0] PORT_A = 3'h0;
  localparam logic [2:0] PORT_B = 3'h1;
  localparam logic [2:0] PORT_C = 3'h2;
  localparam logic [2:0] PORT_D = 3'h3;
  localparam logic [2:0] PORT_E = 3'h4;
  localparam logic [2:0] PORT_F = 3'h5;

  // port that carries lookup table n
  function automatic logic [2:0] tbl_port(input int n);
    unique case (n)
      0: tbl_port = PORT_A;
      1: tbl_port = PORT_C;
      2: tbl_port = PORT_D;
      default: tbl_port = PORT_F;
    endcase
  endfunction : tbl_port

endpackage : prs_pkg

// [verilog/prs_route_reg.sv]
// one byte-wide route register with a mask of implemented bits
// assumes single-cycle write strobes from the register port
module prs_route_reg #(
  parameter logic [7:0] RST_VAL = 8'h00,
  parameter logic [7:0] IMPL_MASK = 8'hFF
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // write side
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  // stored value, unused bits held at zero
  output logic [7:0] value_q
);

  logic [7:0] value_d;  // next stored value

  // only implemented bits take the written data
  assign value_d = wr_en ? (wr_data & IMPL_MASK) : value_q;

  // synchronous reset to the documented value
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      value_q <= RST_VAL & IMPL_MASK;
    end else begin
      value_q <= value_d;
    end
  end

endmodule : prs_route_reg

// [verilog/prs_pin_place.sv]
// places one peripheral output on its default or alternative pin
// purely combinational; the caller registers the merged result
module prs_pin_place #(
  parameter bit HAS_ALT = 1'b1,
  parameter logic [2:0] DEF_PIN = 3'h2,
  parameter logic [2:0] ALT_PIN = 3'h7
) (
  // peripheral side
  input wire logic sig,
  input wire logic sig_en,
  // route select bit as stored
  input wire logic sel,
  // pin masks inside the owning port
  output logic [7:0] pin_oe,
  output logic [7:0] pin_val
);

  logic use_alt;       // alternative pin in effect
  logic [2:0] pin_idx; // chosen pin position

  // a reserved select keeps the signal on its default pin
  assign use_alt = sel & HAS_ALT;
  assign pin_idx = use_alt ? ALT_PIN : DEF_PIN;

  // only the chosen pin is taken over, and only while enabled
  assign pin_oe = sig_en ? (8'h01 << pin_idx) : 8'h00;
  assign pin_val = (sig_en & sig) ? (8'h01 << pin_idx) : 8'h00;

endmodule : prs_pin_place

// [verilog/prs_top.sv]
// peripheral pin route select: routing registers and pin takeover
// assumes the register port master and peripherals share core_clk
//
// Notes on behaviour
// - event route register offset 0, bits 5:0
// - event f: pin f2, alternative reserved
// - event e: pin e2, alternative reserved
// - event d: pin d2 or pin d7
// - event c: pin c2 or pin c7
// - event b: pin b2, alternative reserved
// - event a: pin a2 or pin a7
// - table 3: pin f3 or pin f6
// - table 2: pin d3 or pin d6
// - table 1: pin c3 or pin c6
// - table 0: pin a3 or pin a6
// - serial route offset 2, four 2-bit groups
//
// Our own choice: strobed register access.
module prs_top (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // register port
  input wire logic [prs_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [prs_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [prs_pkg::DATA_W-1:0] reg_rdata_q,
  // event outputs a..f, index 0 is a
  input wire logic [prs_pkg::EVT_NUM-1:0] evt_sig,
  input wire logic [prs_pkg::EVT_NUM-1:0] evt_sig_en,
  // lookup table outputs 0..3
  input wire logic [prs_pkg::TBL_NUM-1:0] tbl_sig,
  input wire logic [prs_pkg::TBL_NUM-1:0] tbl_sig_en,
  // serial pin group selects to the serial port muxes
  output logic [1:0] serial0_pin_group_q,
  output logic [1:0] serial1_pin_group_q,
  output logic [1:0] serial2_pin_group_q,
  output logic [1:0] serial3_pin_group_q,
  // port a takeover
  output logic [7:0] port_a_oe_q,
  output logic [7:0] port_a_out_q,
  // port b takeover
  output logic [7:0] port_b_oe_q,
  output logic [7:0] port_b_out_q,
  // port c takeover
  output logic [7:0] port_c_oe_q,
  output logic [7:0] port_c_out_q,
  // port d takeover
  output logic [7:0] port_d_oe_q,
  output logic [7:0] port_d_out_q,
  // port e takeover
  output logic [7:0] port_e_oe_q,
  output logic [7:0] port_e_out_q,
  // port f takeover
  output logic [7:0] port_f_oe_q,
  output logic [7:0] port_f_out_q
);

  // stored register values
  logic [7:0] evt_route_q;  // event output route
  logic [7:0] tbl_route_q;  // logic-table output route
  logic [7:0] ser_route_q;  // serial port route
  // bits that are not implemented are held at zero in storage

  // address decode
  logic hit_evt;   // event route register addressed
  logic hit_tbl;   // table route register addressed
  logic hit_ser;   // serial route register addressed
  logic wr_evt;    // write to event route
  logic wr_tbl;    // write to table route
  logic wr_ser;    // write to serial route
  logic [7:0] rd_sel;         // value chosen for a read
  logic [7:0] reg_rdata_d;    // next read data

  // per-signal placements inside their port
  // one placement per routed signal, merged port by port below
  logic [7:0] evt_oe [prs_pkg::EVT_NUM];
  logic [7:0] evt_val [prs_pkg::EVT_NUM];
  logic [7:0] tbl_oe [prs_pkg::TBL_NUM];
  logic [7:0] tbl_val [prs_pkg::TBL_NUM];

  // merged per-port takeover, next values
  logic [7:0] port_oe_d [prs_pkg::PORT_NUM];
  logic [7:0] port_out_d [prs_pkg::PORT_NUM];

  // decode is a plain compare against the offsets
  // the whole byte is compared, so no offset above the three registers
  // aliases onto one of them
  assign hit_evt = (reg_addr == prs_pkg::EVT_ROUTE_OFS);
  assign hit_tbl = (reg_addr == prs_pkg::TBL_ROUTE_OFS);
  assign hit_ser = (reg_addr == prs_pkg::SER_ROUTE_OFS);

  // writes to any other address are dropped
  // a read strobe never changes a register, so reads have no side effect
  assign wr_evt = reg_wr & hit_evt;
  assign wr_tbl = reg_wr & hit_tbl;
  assign wr_ser = reg_wr & hit_ser;

  // event route: bits 7:6 are not stored
  // masking at the store keeps readback and routing in step
  prs_route_reg #(
    .RST_VAL(prs_pkg::EVT_ROUTE_RST),
    .IMPL_MASK(prs_pkg::EVT_ROUTE_MASK)
  ) u_evt_route (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .wr_en(wr_evt),
    .wr_data(reg_wdata),
    .value_q(evt_route_q)
  );

  // table route: only four select bits exist
  // the upper nibble reads zero whatever was written to it
  prs_route_reg #(
    .RST_VAL(prs_pkg::TBL_ROUTE_RST),
    .IMPL_MASK(prs_pkg::TBL_ROUTE_MASK)
  ) u_tbl_route (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .wr_en(wr_tbl),
    .wr_data(reg_wdata),
    .value_q(tbl_route_q)
  );

  // serial route: every bit is a field bit
  // reserved field codes are stored and read back unchanged
  prs_route_reg #(
    .RST_VAL(prs_pkg::SER_ROUTE_RST),
    .IMPL_MASK(prs_pkg::SER_ROUTE_MASK)
  ) u_ser_route (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .wr_en(wr_ser),
    .wr_data(reg_wdata),
    .value_q(ser_route_q)
  );

  // read mux: reserved selects read back as written, unmapped reads zero
  // a reserved select reads back as written although its signal stays
  // on the default pin, so software sees what it wrote
  assign rd_sel = hit_evt ? evt_route_q :
                  hit_tbl ? tbl_route_q :
                  hit_ser ? ser_route_q : 8'h00;

  // read data stand only in the cycle after the strobe
  assign reg_rdata_d = reg_rd ? rd_sel : 8'h00;

  // read data register
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      // no stale data survives a reset
      reg_rdata_q <= 8'h00;
    end else begin
      // zero unless a read strobe came the cycle before
      reg_rdata_q <= reg_rdata_d;
    end
  end

  // event outputs: each sits on pin 2 of its own port; only d, c and a
  // have pin 7 as alternative, the others ignore a set select bit
  // the enable gates the takeover: a disabled event leaves its pin to
  // the port's own output driver
  for (genvar i = 0; i < prs_pkg::EVT_NUM; i++) begin : g_evt
    prs_pin_place #(
      .HAS_ALT(prs_pkg::EVT_ALT_MASK[i]),
      .DEF_PIN(prs_pkg::EVT_DEF_PIN),
      .ALT_PIN(prs_pkg::EVT_ALT_PIN)
    ) u_place (
      .sig(evt_sig[i]),
      .sig_en(evt_sig_en[i]),
      .sel(evt_route_q[i]),
      .pin_oe(evt_oe[i]),
      .pin_val(evt_val[i])
    );
  end

  // lookup tables: pin 3 by default, pin 6 as alternative
  // table pins never meet event pins inside one port
  for (genvar j = 0; j < prs_pkg::TBL_NUM; j++) begin : g_tbl
    prs_pin_place #(
      .HAS_ALT(prs_pkg::TBL_ALT_MASK[j]),
      .DEF_PIN(prs_pkg::TBL_DEF_PIN),
      .ALT_PIN(prs_pkg::TBL_ALT_PIN)
    ) u_place (
      .sig(tbl_sig[j]),
      .sig_en(tbl_sig_en[j]),
      .sel(tbl_route_q[j]),
      .pin_oe(tbl_oe[j]),
      .pin_val(tbl_val[j])
    );
  end

  // merge placements into ports; pin positions never collide, since
  // events use pins 2 and 7 and tables use pins 3 and 6
  // every pass starts from all zeros, which keeps the process free of
  // latches
  always_comb begin
    for (int p = 0; p < prs_pkg::PORT_NUM; p++) begin
      port_oe_d[p] = 8'h00;
      port_out_d[p] = 8'h00;
    end
    // event n lives on port n
    for (int i = 0; i < prs_pkg::EVT_NUM; i++) begin
      port_oe_d[i] = port_oe_d[i] | evt_oe[i];
      port_out_d[i] = port_out_d[i] | evt_val[i];
    end
    // tables map onto ports a, c, d and f
    for (int j = 0; j < prs_pkg::TBL_NUM; j++) begin
      port_oe_d[prs_pkg::tbl_port(j)] =
        port_oe_d[prs_pkg::tbl_port(j)] | tbl_oe[j];
      port_out_d[prs_pkg::tbl_port(j)] =
        port_out_d[prs_pkg::tbl_port(j)] | tbl_val[j];
    end
  end

  // takeover outputs are registered: one cycle of lag on the pins is
  // traded for glitch-free outputs into the port multiplexers;
  // each port keeps its own short process
  // port a: event a and lookup table 0
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      port_a_oe_q <= 8'h00;
      port_a_out_q <= 8'h00;
    end else begin
      port_a_oe_q <= port_oe_d[prs_pkg::PORT_A];
      port_a_out_q <= port_out_d[prs_pkg::PORT_A];
    end
  end

  // port b: event b only
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      port_b_oe_q <= 8'h00;
      port_b_out_q <= 8'h00;
    end else begin
      port_b_oe_q <= port_oe_d[prs_pkg::PORT_B];
      port_b_out_q <= port_out_d[prs_pkg::PORT_B];
    end
  end

  // port c: event c and lookup table 1
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      port_c_oe_q <= 8'h00;
      port_c_out_q <= 8'h00;
    end else begin
      port_c_oe_q <= port_oe_d[prs_pkg::PORT_C];
      port_c_out_q <= port_out_d[prs_pkg::PORT_C];
    end
  end

  // port d: event d and lookup table 2
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      port_d_oe_q <= 8'h00;
      port_d_out_q <= 8'h00;
    end else begin
      port_d_oe_q <= port_oe_d[prs_pkg::PORT_D];
      port_d_out_q <= port_out_d[prs_pkg::PORT_D];
    end
  end

  // port e: event e only
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      port_e_oe_q <= 8'h00;
      port_e_out_q <= 8'h00;
    end else begin
      port_e_oe_q <= port_oe_d[prs_pkg::PORT_E];
      port_e_out_q <= port_out_d[prs_pkg::PORT_E];
    end
  end

  // port f: event f and lookup table 3
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      port_f_oe_q <= 8'h00;
      port_f_out_q <= 8'h00;
    end else begin
      port_f_oe_q <= port_oe_d[prs_pkg::PORT_F];
      port_f_out_q <= port_out_d[prs_pkg::PORT_F];
    end
  end

  // serial pin groups: encodings are decoded by the serial port muxes;
  // copies here keep every output straight from a flip-flop
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      // every field selects its default pin group after reset
      serial0_pin_group_q <= 2'h0;
      serial1_pin_group_q <= 2'h0;
      serial2_pin_group_q <= 2'h0;
      serial3_pin_group_q <= 2'h0;
    end else begin
      // the copies lag the stored register by one cycle
      serial0_pin_group_q <= ser_route_q[1:0];
      serial1_pin_group_q <= ser_route_q[3:2];
      serial2_pin_group_q <= ser_route_q[5:4];
      serial3_pin_group_q <= ser_route_q[7:6];
    end
  end

endmodule : prs_top

// [dv/prs_monitor.sv]
// checker for prs_top: register port answers and event pin takeover
// assumes one clock domain and a synchronous active-low reset
module prs_monitor (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // register port
  input wire logic [prs_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [prs_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [prs_pkg::DATA_W-1:0] reg_rdata_q,
  // event sources
  input wire logic [prs_pkg::EVT_NUM-1:0] evt_sig,
  input wire logic [prs_pkg::EVT_NUM-1:0] evt_sig_en,
  // serial fields
  input wire logic [1:0] serial0_pin_group_q,
  input wire logic [1:0] serial1_pin_group_q,
  input wire logic [1:0] serial2_pin_group_q,
  input wire logic [1:0] serial3_pin_group_q,
  // ports with event pins of interest; port f also carries table 3
  input wire logic [7:0] port_b_oe_q,
  input wire logic [7:0] port_b_out_q,
  input wire logic [7:0] port_e_oe_q,
  input wire logic [7:0] port_e_out_q,
  input wire logic [7:0] port_f_oe_q,
  input wire logic [7:0] port_f_out_q
);
  // serial fields gathered back into register order
  wire [7:0] ser = {serial3_pin_group_q, serial2_pin_group_q,
    serial1_pin_group_q, serial0_pin_group_q};
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // read data only in the cycle after a read strobe
  property p_rd_idle; !reg_rd |=> reg_rdata_q == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("stray read data");
  property p_evt_rd;
    reg_rd && reg_addr == 8'h00 |=> reg_rdata_q[7:6] == 2'h0;
  endproperty
  a_evt_rd: assert property (p_evt_rd)
    else $error("event bits 7:6 set");
  property p_tbl_rd;
    reg_rd && reg_addr == 8'h01 |=> reg_rdata_q[7:4] == 4'h0;
  endproperty
  a_tbl_rd: assert property (p_tbl_rd)
    else $error("table bits 7:4 set");
  property p_unmapped;
    reg_rd && reg_addr > 8'h02 |=> reg_rdata_q == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read");
  // serial fields are copies of the stored register, so they show a
  // write two edges after its strobe
  property p_ser_wr;
    reg_wr && reg_addr == 8'h02 |-> ##2 ser == $past(reg_wdata, 2);
  endproperty
  a_ser_wr: assert property (p_ser_wr)
    else $error("serial write lost");
  property p_ser_rd;
    reg_rd && reg_addr == 8'h02 |=> reg_rdata_q == ser;
  endproperty
  a_ser_rd: assert property (p_ser_rd)
    else $error("serial readback");
  // reserved alternatives: b, e and f always stay on pin 2
  property p_evt_b;
    1'b1 |=> port_b_oe_q == {5'h00, $past(evt_sig_en[1]), 2'h0}
      && port_b_out_q == {5'h00, $past(evt_sig[1] & evt_sig_en[1]), 2'h0};
  endproperty
  a_evt_b: assert property (p_evt_b)
    else $error("event b pin");
  property p_evt_e;
    1'b1 |=> port_e_oe_q == {5'h00, $past(evt_sig_en[4]), 2'h0}
      && port_e_out_q == {5'h00, $past(evt_sig[4] & evt_sig_en[4]), 2'h0};
  endproperty
  a_evt_e: assert property (p_evt_e)
    else $error("event e pin");
  property p_evt_f;
    1'b1 |=> port_f_oe_q[2] == $past(evt_sig_en[5])
      && port_f_out_q[2] == $past(evt_sig[5] & evt_sig_en[5]);
  endproperty
  a_evt_f: assert property (p_evt_f)
    else $error("event f pin");
endmodule : prs_monitor
bind prs_top prs_monitor prs_monitor_i (.core_clk(core_clk),
  .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
  .evt_sig(evt_sig), .evt_sig_en(evt_sig_en),
  .serial0_pin_group_q(serial0_pin_group_q),
  .serial1_pin_group_q(serial1_pin_group_q),
  .serial2_pin_group_q(serial2_pin_group_q),
  .serial3_pin_group_q(serial3_pin_group_q),
  .port_b_oe_q(port_b_oe_q), .port_b_out_q(port_b_out_q),
  .port_e_oe_q(port_e_oe_q), .port_e_out_q(port_e_out_q),
  .port_f_oe_q(port_f_oe_q), .port_f_out_q(port_f_out_q));

// [dv/prs_top_tb.sv]
// self-checking bench for prs_top: registers, event and table pins
// assumes the package, design and prs_monitor are compiled first
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin \
  n_fail++; $display("ERROR %0t: got %h want %h", $time, got, exp); end end
module prs_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // stimulus and observed outputs
  logic core_clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
  logic [5:0] evt_sig = 6'h00, evt_sig_en = 6'h00;
  logic [3:0] tbl_sig = 4'h0, tbl_sig_en = 4'h0;
  wire [7:0] rdata;
  wire [1:0] sg [4];
  wire [7:0] oe [6];
  wire [7:0] pout [6];
  int n_fail = 0, comparisons = 0;
  // 25 MHz clock
  always #20 core_clk = ~core_clk;
  prs_top prs_top_i (.core_clk(core_clk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata_q(rdata), .evt_sig(evt_sig),
    .evt_sig_en(evt_sig_en), .tbl_sig(tbl_sig), .tbl_sig_en(tbl_sig_en),
    .serial0_pin_group_q(sg[0]), .serial1_pin_group_q(sg[1]),
    .serial2_pin_group_q(sg[2]), .serial3_pin_group_q(sg[3]),
    .port_a_oe_q(oe[0]), .port_a_out_q(pout[0]), .port_b_oe_q(oe[1]),
    .port_b_out_q(pout[1]), .port_c_oe_q(oe[2]), .port_c_out_q(pout[2]),
    .port_d_oe_q(oe[3]), .port_d_out_q(pout[3]), .port_e_oe_q(oe[4]),
    .port_e_out_q(pout[4]), .port_f_oe_q(oe[5]), .port_f_out_q(pout[5]));
  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  // one-cycle read strobe; data is taken in the following cycle only
  task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(rdata, exp)
  endtask : chk_rd
  // reset for two edges with sources idle, then all must read zero
  task automatic t_reset_values;
    reset_n <= 1'b0;
    evt_sig_en <= 6'h00;
    tbl_sig_en <= 4'h0;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    #1;
    for (int p = 0; p < 6; p++) `CHK(oe[p] | pout[p], 8'h00)
    `CHK({sg[3], sg[2], sg[1], sg[0]}, 8'h00)
    chk_rd(8'h00, 8'h00);
    chk_rd(8'h01, 8'h00);
    chk_rd(8'h02, 8'h00);
  endtask : t_reset_values
  // all ones everywhere, unused bits and the unmapped offset drop them
  task automatic t_masks;
    for (int a = 0; a < 4; a++) wr(8'(a), 8'hFF);
    chk_rd(8'h00, 8'h3F);
    chk_rd(8'h01, 8'h0F);
    chk_rd(8'h02, 8'hFF);
    chk_rd(8'h03, 8'h00);
  endtask : t_masks
  // each event on both selects; reserved ones must stay on pin 2
  task automatic t_events;
    logic [7:0] exp;
    for (int n = 0; n < 6; n++) begin
      for (int s = 0; s < 2; s++) begin
        @(posedge core_clk);
        evt_sig_en <= 6'h01 << n;
        evt_sig <= 6'(s << n);
        wr(8'h00, 8'(s << n));
        @(posedge core_clk);
        #1;
        exp = (s == 1 && prs_pkg::EVT_ALT_MASK[n]) ? 8'h80 : 8'h04;
        `CHK(oe[n], exp)
        `CHK(pout[n], s ? exp : 8'h00)
        chk_rd(8'h00, 8'(s << n));
      end
    end
  endtask : t_events
  // each lookup table on both selects, on its own port
  task automatic t_tables;
    int tp[4] = '{0, 2, 3, 5};
    logic [7:0] exp;
    for (int n = 0; n < 4; n++) begin
      for (int s = 0; s < 2; s++) begin
        @(posedge core_clk);
        evt_sig_en <= 6'h00;
        tbl_sig_en <= 4'h1 << n;
        tbl_sig <= 4'(s << n);
        wr(8'h01, 8'(s << n));
        @(posedge core_clk);
        #1;
        exp = s ? 8'h40 : 8'h08;
        `CHK(oe[tp[n]], exp)
        `CHK(pout[tp[n]], s ? exp : 8'h00)
        chk_rd(8'h01, 8'(s << n));
      end
    end
  endtask : t_tables
  // four distinct field values land on the right serial ports
  task automatic t_serial;
    wr(8'h02, 8'hE4);
    // the field outputs copy the stored register one edge later
    @(posedge core_clk);
    #1;
    `CHK({sg[3], sg[2], sg[1], sg[0]}, 8'hE4)
    chk_rd(8'h02, 8'hE4);
  endtask : t_serial
  // verdict and the end of the run
  task automatic end_of_test;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test
  // main sequence, with a reset in mid-run after the mask test
  initial begin
    t_reset_values();
    t_masks();
    // start the mid-run reset on a clock edge
    @(posedge core_clk);
    t_reset_values();
    t_events();
    t_tables();
    t_serial();
    end_of_test();
  end
  // the whole run needs well under 2000 cycles
  initial begin
    #200000;
    n_fail++;
    end_of_test();
  end
endmodule : prs_top_tb
